//--- verilog/tmhp_params.svh
// Register offsets, field positions, reset values and limits of the TAP master host port.
`ifndef TMHP_PARAMS_SVH
`define TMHP_PARAMS_SVH

`define TMHP_IDX_CONFIG_A      3'h0
`define TMHP_IDX_CONFIG_B      3'h1
`define TMHP_IDX_STATUS        3'h2
`define TMHP_IDX_COMMAND       3'h3
`define TMHP_IDX_SHIFT_OUT     3'h4
`define TMHP_IDX_SHIFT_IN      3'h5
`define TMHP_IDX_COUNTER       3'h6
`define TMHP_IDX_PIN_CONTROL   3'h7

`define TMHP_RST_CONFIG_A      8'h00
`define TMHP_RST_CONFIG_B      8'h80
`define TMHP_RST_COMMAND       8'h00
`define TMHP_RST_SHIFT_OUT     8'h00
`define TMHP_RST_SHIFT_IN      8'h00
`define TMHP_RST_COUNTER       8'h00
`define TMHP_RST_PIN_CONTROL   8'h00

`define TMHP_BIT_SIN_DATA      7
`define TMHP_BIT_SOUT_FULL     6
`define TMHP_BIT_COUNTER_STATE 5
`define TMHP_BIT_SOFT_RESET    7
`define TMHP_OPCODE_MSB        3
`define TMHP_OPCODE_LSB        0
`define TMHP_RETIMING_DELAY_FIELD_MSB          3
`define TMHP_RETIMING_DELAY_FIELD_LSB          0
`define TMHP_PIN_CONTROL_MASK  8'h0F
`define TMHP_CONFIG_A_MASK     8'h3F

`define TMHP_LEAD_LIMIT        5

`endif

//--- verilog/tmhp_pkg.sv
// Types shared by the TAP master host port, its property checks and its testbench.
package tmhp_pkg;

    typedef struct packed {
        logic       strobe_n;
        logic       readSel;
        logic [2:0] registerIndex;
        logic [7:0] data;
    } tmhp_host_pins_t;

    typedef struct packed {
        logic       commandDone;
        logic       shiftOutClearing;
        logic       fullDuplexScan;
        logic       counterState;
        logic [3:0] tapState;
        logic       shiftOutTake;
        logic       shiftInLoad;
        logic [7:0] shiftInData;
        logic [7:0] counterReadData;
    } tmhp_engine_status_t;

    typedef struct packed {
        logic [7:0] configA;
        logic [7:0] configB;
        logic [7:0] command;
        logic [7:0] pinControl;
        logic [7:0] shiftOutData;
        logic       shiftOutValid;
        logic       counterWrite;
        logic [7:0] counterData;
        logic       softwareReset;
    } tmhp_engine_ctrl_t;

    typedef enum logic [0:0] {
        TMHP_ACC_IDLE   = 1'b0,
        TMHP_ACC_ACTIVE = 1'b1
    } tmhp_access_state_t;

endpackage : tmhp_pkg

//--- verilog/tmhp_sync.sv
// Two-stage synchroniser for the host pin bundle.
`timescale 1ns/100ps
`default_nettype none

module tmhp_sync #(
    parameter int WIDTH = 13
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stageOne;

    if (WIDTH < 1) begin : g_bad_width
        $error("Synchroniser width must be at least one.");
    end

    // Strobe idles high, so the reset value holds every bit high.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stageOne <= {WIDTH{1'b1}};
            syncOut  <= {WIDTH{1'b1}};
        end else begin
            stageOne <= asyncIn;
            syncOut  <= stageOne;
        end
    end

endmodule : tmhp_sync

`default_nettype wire

//--- verilog/tmhp_host_port.sv
// Host register port of the TAP master: pins, ready, register map and buffer flags.
//
// Functional notes
// - Register accesses are timed by the access strobe only, not the input clock; here the strobe is synchronised and sampled on sys_clk.
// - Read with select high drives the indexed register onto the bus.
// - Data bus is released whenever the access strobe is high.
// - Write with select low never drives the data bus.
// - Write index is captured at the strobe falling edge.
// - Write data is captured at the strobe rising edge.
// - Blocked access drives ready low until the condition clears, then completes.
// - Shift-in read while that buffer is empty waits for data.
// - Shift-out write waits while that buffer is full or being cleared.
// - Nonzero opcode blocks command, configuration and counter writes until done.
// - Writing one to the software reset bit is never blocked.
// - Full-duplex retimed scan: shift-out writes lead shift-in reads by five at most.
// - All registers read; status and shift-in are read-only.
// - Pin control writes during a running command are held off too; shift-out writes are not.
// - Reserved bits of read-only registers read as zero.
// - Index map of eight registers, configuration B resets to 0x80.
`timescale 1ns/100ps
`default_nettype none
`include "tmhp_params.svh"

module tmhp_host_port #(
    parameter int DATA_W     = 8,
    parameter int LEAD_LIMIT = `TMHP_LEAD_LIMIT
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         access_strobe_n,
    input  wire logic                         readSel,
    input  wire logic [2:0]                   register_index,
    input  wire logic [DATA_W-1:0]            host_data_in,
    output logic      [DATA_W-1:0]            host_data_out,
    output logic                              host_data_oe_n,
    output logic                              ready,
    input  wire tmhp_pkg::tmhp_engine_status_t engineStatus,
    output tmhp_pkg::tmhp_engine_ctrl_t       engineCtrl
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks and declarations.

    if (DATA_W != 8) begin : g_bad_data_w
        $error("The host data bus must be eight bits wide.");
    end
    if (LEAD_LIMIT < 1 || LEAD_LIMIT > 7) begin : g_bad_lead_limit
        $error("Lead limit must lie between one and seven.");
    end

    tmhp_pkg::tmhp_host_pins_t    rawPins;
    tmhp_pkg::tmhp_host_pins_t    syncPins;
    tmhp_pkg::tmhp_access_state_t accessState;
    logic                         strobeFall;
    logic                         strobeRise;
    logic [2:0]                   capturedIndex;
    logic                         capturedRead;
    logic [7:0]                   configA;
    logic [7:0]                   configB;
    logic [7:0]                   command;
    logic [7:0]                   shiftOut;
    logic [7:0]                   shiftIn;
    logic [7:0]                   pinControl;
    logic [7:0]                   counterData;
    logic                         shiftOutFull;
    logic                         shiftInFull;
    logic [2:0]                   leadCount;
    logic                         leadActive;
    logic                         commandBusy;
    logic [7:0]                   statusValue;
    logic                         commitWrite;
    logic                         commitRead;
    logic                         softReset;
    logic                         counterWrite;
    logic                         shiftInShown;
    logic                         counterWritePulse;
    logic                         softResetPulse;

    ////////////////////////////////////////////////////////////////////////////////
    // Blocking decode, shared by the ready output and the commit logic.

    function automatic logic guardedIndex(input logic [2:0] idx);
        guardedIndex = (idx != `TMHP_IDX_SHIFT_OUT) && (idx != `TMHP_IDX_STATUS)
                    && (idx != `TMHP_IDX_SHIFT_IN);
    endfunction : guardedIndex

    function automatic logic accessBlocked(
        input logic       isRead,
        input logic [2:0] idx,
        input logic [7:0] wdata
    );
        logic softWrite;
        softWrite = (idx == `TMHP_IDX_COMMAND) && wdata[`TMHP_BIT_SOFT_RESET];
        if (isRead) begin
            accessBlocked = (idx == `TMHP_IDX_SHIFT_IN)
                         && !(shiftInFull && shiftInShown);
        end else if (idx == `TMHP_IDX_SHIFT_OUT) begin
            accessBlocked = shiftOutFull || engineStatus.shiftOutClearing
                         || (leadActive && leadCount >= LEAD_LIMIT[2:0]);
        end else begin
            accessBlocked = commandBusy && guardedIndex(idx) && !softWrite;
        end
    endfunction : accessBlocked

    assign commandBusy = command[`TMHP_OPCODE_MSB:`TMHP_OPCODE_LSB] != 4'h0;
    assign leadActive  = engineStatus.fullDuplexScan
                      && (configB[`TMHP_RETIMING_DELAY_FIELD_MSB:`TMHP_RETIMING_DELAY_FIELD_LSB] != 4'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin side: bus drivers and ready follow the strobe directly.

    assign rawPins.strobe_n      = access_strobe_n;
    assign rawPins.readSel       = readSel;
    assign rawPins.registerIndex = register_index;
    assign rawPins.data          = host_data_in;

    // Drivers on only while strobe is low with read select high.
    assign host_data_oe_n = access_strobe_n || !readSel;

    // Ready drops for the length of a blocked access and rises when it clears.
    always_comb begin
        ready = access_strobe_n
             || !accessBlocked(readSel, register_index, host_data_in);
    end

    tmhp_sync #(
        .WIDTH ($bits(tmhp_pkg::tmhp_host_pins_t))
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (rawPins),
        .syncOut (syncPins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Access tracking on the synchronised strobe.

    assign strobeFall = (accessState == tmhp_pkg::TMHP_ACC_IDLE) && !syncPins.strobe_n;
    assign strobeRise = (accessState == tmhp_pkg::TMHP_ACC_ACTIVE) && syncPins.strobe_n;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accessState <= tmhp_pkg::TMHP_ACC_IDLE;
        end else begin
            unique case (accessState)
                tmhp_pkg::TMHP_ACC_IDLE: begin
                    if (strobeFall) begin
                        accessState <= tmhp_pkg::TMHP_ACC_ACTIVE;
                    end
                end
                tmhp_pkg::TMHP_ACC_ACTIVE: begin
                    if (strobeRise) begin
                        accessState <= tmhp_pkg::TMHP_ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // Index and direction are held from the falling edge; the host keeps them stable.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capturedIndex <= 3'h0;
            capturedRead  <= 1'b1;
        end else if (strobeFall) begin
            capturedIndex <= syncPins.registerIndex;
            capturedRead  <= syncPins.readSel;
        end
    end

    // An access still blocked at its rising edge is discarded.
    always_comb begin
        commitWrite = strobeRise && !capturedRead
                   && !accessBlocked(1'b0, capturedIndex, syncPins.data);
        commitRead  = strobeRise && capturedRead
                   && !accessBlocked(1'b1, capturedIndex, syncPins.data);
    end
    assign softReset   = commitWrite && (capturedIndex == `TMHP_IDX_COMMAND)
                      && syncPins.data[`TMHP_BIT_SOFT_RESET];
    assign counterWrite = commitWrite && (capturedIndex == `TMHP_IDX_COUNTER);

    ////////////////////////////////////////////////////////////////////////////////
    // Writable registers; status and shift-in accept no host write.

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            configA    <= `TMHP_RST_CONFIG_A;
            configB    <= `TMHP_RST_CONFIG_B;
            pinControl <= `TMHP_RST_PIN_CONTROL;
            counterData <= `TMHP_RST_COUNTER;
        end else if (commitWrite) begin
            unique case (capturedIndex)
                `TMHP_IDX_CONFIG_A: begin
                    configA <= syncPins.data & `TMHP_CONFIG_A_MASK;
                end
                `TMHP_IDX_CONFIG_B: begin
                    configB <= syncPins.data;
                end
                `TMHP_IDX_PIN_CONTROL: begin
                    pinControl <= syncPins.data & `TMHP_PIN_CONTROL_MASK;
                end
                `TMHP_IDX_COUNTER: begin
                    counterData <= syncPins.data;
                end
                default: begin
                    configA <= configA;
                end
            endcase
        end
    end

    // Command register: opcode cleared by the engine, a host write wins the same cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            command <= `TMHP_RST_COMMAND;
        end else if (softReset) begin
            command <= `TMHP_RST_COMMAND;
        end else if (commitWrite && capturedIndex == `TMHP_IDX_COMMAND) begin
            command <= syncPins.data;
        end else if (engineStatus.commandDone) begin
            command[`TMHP_OPCODE_MSB:`TMHP_OPCODE_LSB] <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift-out and shift-in buffers.

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shiftOut     <= `TMHP_RST_SHIFT_OUT;
            shiftOutFull <= 1'b0;
        end else if (commitWrite && capturedIndex == `TMHP_IDX_SHIFT_OUT) begin
            shiftOut     <= syncPins.data;
            shiftOutFull <= 1'b1;
        end else if (softReset || engineStatus.shiftOutClearing || engineStatus.shiftOutTake) begin
            shiftOutFull <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shiftIn     <= `TMHP_RST_SHIFT_IN;
            shiftInFull <= 1'b0;
        end else if (engineStatus.shiftInLoad) begin
            shiftIn     <= engineStatus.shiftInData;
            shiftInFull <= 1'b1;
        end else if (softReset
                  || (commitRead && capturedIndex == `TMHP_IDX_SHIFT_IN)) begin
            shiftInFull <= 1'b0;
        end
    end

    // Count of shift-out writes ahead of shift-in reads during a retimed scan.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            leadCount <= 3'h0;
        end else if (!leadActive || softReset) begin
            leadCount <= 3'h0;
        end else begin
            unique case ({commitWrite && capturedIndex == `TMHP_IDX_SHIFT_OUT,
                          commitRead && capturedIndex == `TMHP_IDX_SHIFT_IN})
                2'b10: begin
                    leadCount <= leadCount + 3'h1;
                end
                2'b01: begin
                    if (leadCount != 3'h0) begin
                        leadCount <= leadCount - 3'h1;
                    end
                end
                default: begin
                    leadCount <= leadCount;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data path.

    always_comb begin
        statusValue                          = 8'h00;
        statusValue[`TMHP_BIT_SIN_DATA]      = shiftInFull;
        statusValue[`TMHP_BIT_SOUT_FULL]     = shiftOutFull || engineStatus.shiftOutClearing;
        statusValue[`TMHP_BIT_COUNTER_STATE] = engineStatus.counterState;
        statusValue[3:0]                     = engineStatus.tapState;
    end

    // Read data follows the index every clock and is stable before the strobe rises.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_data_out <= 8'h00;
            shiftInShown  <= 1'b0;
        end else begin
            shiftInShown  <= shiftInFull;
            unique case (syncPins.registerIndex)
                `TMHP_IDX_CONFIG_A:    host_data_out <= configA;
                `TMHP_IDX_CONFIG_B:    host_data_out <= configB;
                `TMHP_IDX_STATUS:      host_data_out <= statusValue;
                `TMHP_IDX_COMMAND:     host_data_out <= command;
                `TMHP_IDX_SHIFT_OUT:   host_data_out <= shiftOut;
                `TMHP_IDX_SHIFT_IN:    host_data_out <= shiftIn;
                `TMHP_IDX_COUNTER:     host_data_out <= engineStatus.counterReadData;
                `TMHP_IDX_PIN_CONTROL: host_data_out <= pinControl;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Engine-side outputs.

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            counterWritePulse <= 1'b0;
            softResetPulse    <= 1'b0;
        end else begin
            counterWritePulse <= counterWrite;
            softResetPulse    <= softReset;
        end
    end

    assign engineCtrl.configA       = configA;
    assign engineCtrl.configB       = configB;
    assign engineCtrl.command       = command;
    assign engineCtrl.pinControl    = pinControl;
    assign engineCtrl.shiftOutData  = shiftOut;
    assign engineCtrl.shiftOutValid = shiftOutFull;
    assign engineCtrl.counterData   = counterData;
    assign engineCtrl.counterWrite  = counterWritePulse;
    assign engineCtrl.softwareReset = softResetPulse;

endmodule : tmhp_host_port

`default_nettype wire

//--- tb/tmhp_host_port_props.sv
// Concurrent checks on the pins and engine side of the TAP master host port.
`timescale 1ns/100ps
`default_nettype none

module tmhp_host_port_props #(
    parameter int DATA_W     = 8,
    parameter int LEAD_LIMIT = 5
) (
    input wire logic                          sys_clk,
    input wire logic                          rst,
    input wire logic                          access_strobe_n,
    input wire logic                          readSel,
    input wire logic [2:0]                    register_index,
    input wire logic [DATA_W-1:0]             host_data_in,
    input wire logic [DATA_W-1:0]             host_data_out,
    input wire logic                          host_data_oe_n,
    input wire logic                          ready,
    input wire tmhp_pkg::tmhp_engine_status_t engineStatus,
    input wire tmhp_pkg::tmhp_engine_ctrl_t   engineCtrl
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    property p_bus_free_idle;
        access_strobe_n |-> host_data_oe_n;
    endproperty
    a_bus_free_idle : assert property (p_bus_free_idle)
        else $error("data bus driven while strobe high");
    property p_bus_free_write;
        !readSel |-> host_data_oe_n;
    endproperty
    a_bus_free_write : assert property (p_bus_free_write)
        else $error("data bus driven during write");
    property p_bus_on_read;
        !access_strobe_n && readSel |-> !host_data_oe_n;
    endproperty
    a_bus_on_read : assert property (p_bus_on_read)
        else $error("data bus not driven during read");
    property p_ready_idle;
        access_strobe_n |-> ready;
    endproperty
    a_ready_idle : assert property (p_ready_idle)
        else $error("ready low outside an access");
    property p_sout_block;
        !access_strobe_n && !readSel && register_index == 3'h4
            && (engineCtrl.shiftOutValid || engineStatus.shiftOutClearing) |-> !ready;
    endproperty
    a_sout_block : assert property (p_sout_block)
        else $error("shift-out write not held off");
    property p_busy_block;
        !access_strobe_n && !readSel && register_index inside {3'h0, 3'h1, 3'h6, 3'h7}
            && engineCtrl.command[3:0] != 4'h0 |-> !ready;
    endproperty
    a_busy_block : assert property (p_busy_block)
        else $error("write not held off during command");
    property p_software_reset_bit_free;
        !access_strobe_n && !readSel && register_index == 3'h3 && host_data_in[7] |-> ready;
    endproperty
    a_software_reset_bit_free : assert property (p_software_reset_bit_free)
        else $error("software reset write blocked");
    property p_reset_values;
        $fell(rst) |-> engineCtrl.configB == 8'h80 && engineCtrl.configA == 8'h00
            && engineCtrl.command == 8'h00 && !engineCtrl.shiftOutValid;
    endproperty
    a_reset_values : assert property (p_reset_values)
        else $error("wrong register value after reset");
    property p_write_after_rise;
        $changed(engineCtrl.configA) |-> access_strobe_n && $past(access_strobe_n);
    endproperty
    a_write_after_rise : assert property (p_write_after_rise)
        else $error("register changed before strobe rise");

    ////////////////////////////////////////////////////////////////////////////////
    c_read_stall  : cover property (!access_strobe_n && readSel && !ready);
    c_write_stall : cover property (!access_strobe_n && !readSel && !ready);
    c_software_reset_bit       : cover property (engineCtrl.softwareReset);
endmodule : tmhp_host_port_props

bind tmhp_host_port tmhp_host_port_props #(
    .DATA_W     (DATA_W),
    .LEAD_LIMIT (LEAD_LIMIT)
) u_props (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .access_strobe_n (access_strobe_n),
    .readSel         (readSel),
    .register_index  (register_index),
    .host_data_in    (host_data_in),
    .host_data_out   (host_data_out),
    .host_data_oe_n  (host_data_oe_n),
    .ready           (ready),
    .engineStatus    (engineStatus),
    .engineCtrl      (engineCtrl)
);
`default_nettype wire

//--- tb/tmhp_host_model.sv
// Host processor model that runs strobe-timed accesses on the register bus.
`timescale 1ns/100ps
`default_nettype none

module tmhp_host_model (
    input  wire logic       sys_clk,
    input  wire logic       ready,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe_n,
    output logic            strobeN,
    output logic            rdSel,
    output logic [2:0]      regIndex,
    output logic [7:0]      busLevel
);
    logic [7:0] wrData = 8'h00;
    logic       wrDrive = 1'b0;
    logic [7:0] lastBus = 8'h00;

    // A bus that nobody drives shows the inverse of its last level.
    assign busLevel = !host_data_oe_n ? host_data_out : (wrDrive ? wrData : ~lastBus);
    always @(posedge sys_clk) lastBus <= busLevel;
    initial begin
        strobeN = 1'b1;
        rdSel = 1'b1;
        regIndex = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic access(input logic isRd, input logic [2:0] idx, input logic [7:0] wd,
                          input int maxWait, output logic [7:0] rd, output logic ok);
        int n;
        @(posedge sys_clk);
        #1;
        rdSel = isRd;
        regIndex = idx;
        wrData = wd;
        wrDrive = !isRd;
        strobeN = 1'b0;
        repeat (4) @(posedge sys_clk);
        n = 0;
        while (ready !== 1'b1 && n < maxWait) begin
            @(posedge sys_clk);
            n++;
        end
        ok = (ready === 1'b1);
        rd = busLevel;
        #1;
        strobeN = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        wrDrive = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : access
endmodule : tmhp_host_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench of the TAP master host port.
`timescale 1ns/100ps
`default_nettype none

module tb;
    typedef struct {logic [2:0] idx; logic [7:0] wd; logic [7:0] exp;} tmhp_row_t;
    logic                          sys_clk = 1'b0;
    logic                          rst = 1'b1;
    tmhp_pkg::tmhp_engine_status_t es = '0;
    tmhp_pkg::tmhp_engine_ctrl_t   ec;
    logic                          strobeN, rdSel, ready, oeN, ok, swSeen, cwSeen;
    logic [2:0]                    idx;
    logic [7:0]                    busLevel, dout, rd;
    int                            failures = 0;
    int                            samples_checked = 0;
    tmhp_row_t                     rows [5] = '{'{3'h0, 8'h2A, 8'h2A}, '{3'h1, 8'h45, 8'h45},
        '{3'h2, 8'hEF, 8'h29}, '{3'h6, 8'h33, 8'h5A}, '{3'h7, 8'h0A, 8'h0A}};

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rst) swSeen <= 1'b0; else if (ec.softwareReset) swSeen <= 1'b1;
    always @(posedge sys_clk) if (rst) cwSeen <= 1'b0; else if (ec.counterWrite) cwSeen <= 1'b1;

    tmhp_host_port u_dut (.sys_clk(sys_clk), .rst(rst), .access_strobe_n(strobeN),
        .readSel(rdSel), .register_index(idx), .host_data_in(busLevel), .host_data_out(dout),
        .host_data_oe_n(oeN), .ready(ready), .engineStatus(es), .engineCtrl(ec));
    tmhp_host_model u_host (.sys_clk(sys_clk), .ready(ready), .host_data_out(dout),
        .host_data_oe_n(oeN), .strobeN(strobeN), .rdSel(rdSel), .regIndex(idx),
        .busLevel(busLevel));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic pulse(input int which);
        @(posedge sys_clk);
        #1;
        es.shiftInLoad = (which == 0);
        es.shiftOutTake = (which == 1);
        es.commandDone = (which == 2);
        @(posedge sys_clk);
        #1;
        es.shiftInLoad = 1'b0;
        es.shiftOutTake = 1'b0;
        es.commandDone = 1'b0;
    endtask : pulse
    task automatic stall(input int which);
        repeat (12) @(posedge sys_clk);
        #1;
        chk(ready, 1'b0, "ready during blocked access");
        pulse(which);
    endtask : stall
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        u_host.access(1'b0, i, d, 100, rd, ok);
        chk(ok, 1'b1, "write granted");
    endtask : wr
    task automatic rdchk(input logic [2:0] i, input logic [7:0] e);
        u_host.access(1'b1, i, 8'h00, 100, rd, ok);
        chk(ok, 1'b1, "read granted");
        chk(rd, e, "read data");
    endtask : rdchk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        es.tapState = 4'h9;
        es.counterState = 1'b1;
        es.shiftInData = 8'hC3;
        es.counterReadData = 8'h5A;
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            if (i != 2 && i != 5) rdchk(i[2:0], i == 1 ? 8'h80 : (i == 6 ? 8'h5A : 8'h00));
        end
        $display("test reset values done");
        foreach (rows[r]) begin
            wr(rows[r].idx, rows[r].wd);
            rdchk(rows[r].idx, rows[r].exp);
        end
        chk(ec.counterData, 8'h33, "counter write");
        chk(cwSeen, 1'b1, "counter write pulse");
        chk(ec.configB, 8'h45, "config B out");
        chk(ec.pinControl, 8'h0A, "pin control out");
        $display("test register table done");
        fork
            u_host.access(1'b1, 3'h5, 8'h00, 100, rd, ok);
            stall(0);
        join
        chk(rd, 8'hC3, "shift-in read");
        chk(ok, 1'b1, "shift-in read granted");
        rdchk(3'h2, 8'h29);
        $display("test shift-in wait done");
        wr(3'h4, 8'h11);
        chk(ec.shiftOutValid, 1'b1, "shift-out valid");
        rdchk(3'h2, 8'h69);
        fork
            wr(3'h4, 8'h22);
            stall(1);
        join
        chk(ec.shiftOutData, 8'h22, "shift-out data");
        pulse(1);
        es.shiftOutClearing = 1'b1;
        u_host.access(1'b0, 3'h4, 8'h44, 10, rd, ok);
        chk(ok, 1'b0, "write while clearing");
        es.shiftOutClearing = 1'b0;
        chk(ec.shiftOutData, 8'h22, "abandoned write");
        $display("test shift-out wait done");
        wr(3'h3, 8'h02);
        fork
            wr(3'h0, 8'h15);
            stall(2);
        join
        rdchk(3'h0, 8'h15);
        rdchk(3'h3, 8'h00);
        wr(3'h3, 8'h03);
        u_host.access(1'b0, 3'h3, 8'h80, 0, rd, ok);
        chk(ok, 1'b1, "software reset granted");
        chk(swSeen, 1'b1, "software reset pulse");
        rdchk(3'h3, 8'h00);
        $display("test command busy done");
        es.fullDuplexScan = 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(3'h4, i[7:0]);
            pulse(1);
        end
        u_host.access(1'b0, 3'h4, 8'hAA, 12, rd, ok);
        chk(ok, 1'b0, "write beyond lead");
        chk(ec.shiftOutData, 8'h04, "lead write discarded");
        pulse(0);
        rdchk(3'h5, 8'hC3);
        wr(3'h4, 8'hAA);
        chk(ec.shiftOutData, 8'hAA, "write after read");
        $display("test lead limit done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
